//--- inc/ref_stage_params.svh
// offsets, field positions, reset values and counts for the residual differential stage
// assumes a wishbone slave with 32-bit data and byte addresses
`ifndef REF_STAGE_PARAMS_SVH
`define REF_STAGE_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define REF_ADR_CTRL     8'h00
`define REF_ADR_CMD      8'h04
`define REF_ADR_STATUS   8'h08
`define REF_ADR_TRIP_CNT 8'h0c
`define REF_ADR_BLK_CNT  8'h10
`define REF_ADR_LOG_PTR  8'h14
`define REF_ADR_LOG_SEL  8'h18
`define REF_ADR_LOG_DATA 8'h1c

// ****************************************
// control fields
// ****************************************
`define REF_CTRL_DIR_BIT   0
`define REF_CTRL_INSEL_BIT 1
`define REF_CTRL_MASK_LSB  4
`define REF_CTRL_MASK_MSB  7
`define REF_CTRL_RESET     8'hf0

// ****************************************
// command and select fields
// ****************************************
`define REF_CMD_CLR_TRIP_BIT 0
`define REF_CMD_CLR_BLK_BIT  1
`define REF_SEL_WORD_LSB     0
`define REF_SEL_WORD_MSB     2
`define REF_SEL_IDX_LSB      4
`define REF_SEL_IDX_MSB      7
`define REF_LOG_WORDS        6

// ****************************************
// event bit positions
// ****************************************
`define REF_EV_TRIP_ON  0
`define REF_EV_TRIP_OFF 1
`define REF_EV_BLK_ON   2
`define REF_EV_BLK_OFF  3

// ****************************************
// timing
// ****************************************
`define REF_CLK_HZ        40000000
`define REF_BLK_LEAD_MS   5
`define REF_BLK_LEAD_CYC  ((`REF_BLK_LEAD_MS * `REF_CLK_HZ) / 1000)

`endif

//--- inc/ref_stage_pkg.sv
// types shared by the residual differential stage
// assumes ref_stage_params.svh is on the include path
package ref_stage_pkg;

  typedef enum logic [1:0]
  {
    COND_NORMAL  = 2'b00,
    COND_TRIP    = 2'b01,
    COND_BLOCKED = 2'b10
  } cond_e;

  typedef struct packed
  {
    logic [47:0] stamp;
    logic [1:0]  event_code;
    logic [2:0]  group;
    logic [15:0] bias;
    logic [15:0] diff;
    logic [15:0] chr;
    logic [15:0] bias_max;
    logic [15:0] diff_max;
    logic [15:0] chr_max;
    logic [15:0] calc;
    logic [15:0] meas;
  } log_rec_s;

endpackage : ref_stage_pkg

//--- design/ref_stage.sv
// blocking arbitration, condition, events, counters and record log of the residual differential stage
// assumes all inputs except i_block_in come from logic on i_sys_clk; i_cycle_tick pulses once per program cycle
// How it works
// - blocking input sampled at each program cycle start, used all that cycle
// - pick-up with no block sets trip, timing continues outside
// - pick-up arriving while blocked sets blocked, nothing further done
// - block after trip clears trip, release path as on pick-up drop
// - per-event mask picks which of on and off transitions are stored
// - each stored event carries the time stamp
// - trip and blocked counters count each occurrence, cleared by command
// - four events: trip on, trip off, block on, block off
// - circular log keeps twelve latest records, written at on transitions
// - record holds time, event, bias, diff, threshold, maxima, residuals, group
// - differential formed from computed and measured residual of own side
// - read-only condition shows normal, trip or blocked
// - differential is phase sum plus or minus chosen residual input
`include "ref_stage_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ref_stage
  import ref_stage_pkg::*;
#(
  parameter int CUR_W     = 16,
  parameter int CNT_W     = 32,
  parameter int LOG_DEPTH = 12
)
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [7:0]        i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic      [31:0]       o_wb_dat,
  output logic                   o_wb_ack,
  input  wire logic              i_cycle_tick,
  input  wire logic              i_block_in,
  input  wire logic              i_pickup,
  input  wire logic [CUR_W-1:0]  i_computed_residual_current,
  input  wire logic [CUR_W-1:0]  i_measured_residual_current_1,
  input  wire logic [CUR_W-1:0]  i_measured_residual_current_2,
  input  wire logic [CUR_W-1:0]  i_bias_current,
  input  wire logic [CUR_W-1:0]  i_threshold_current,
  input  wire logic [47:0]       i_time_stamp,
  input  wire logic [2:0]        i_setting_group,
  output logic                   o_trip,
  output logic                   o_blocked,
  output logic      [1:0]        o_condition,
  output logic      [CUR_W-1:0]  o_diff_current,
  output logic      [3:0]        o_event_pulse,
  output logic      [3:0]        o_event_store,
  output logic      [47:0]       o_event_stamp
);

  // index is four bits and read words are 16-bit current fields
  if (CUR_W < 1 || CUR_W > 16 || CNT_W < 1 || CNT_W > 32 || LOG_DEPTH < 1 || LOG_DEPTH > 16)
  begin : g_bad_params
    $error("unsupported parameter value");
  end

  localparam logic [3:0] LAST_IDX = 4'(LOG_DEPTH - 1);

  // ****************************************
  // blocking input synchroniser
  // ****************************************
  // blocking matrix output may not share our clock, so two stages first
  logic blk_meta_r;
  logic blk_sync_r;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      blk_meta_r <= 1'b0;
      blk_sync_r <= 1'b0;
    end
    else
    begin
      blk_meta_r <= i_block_in;
      blk_sync_r <= blk_meta_r;
    end
  end

  // ****************************************
  // register file state
  // ****************************************
  logic [7:0]       ctrl_r,     ctrl_nxt;
  logic [7:0]       sel_r,      sel_nxt;
  logic [CNT_W-1:0] trip_cnt_r, trip_cnt_nxt;
  logic [CNT_W-1:0] blk_cnt_r,  blk_cnt_nxt;
  logic [31:0]      rdat_r,     rdat_nxt;
  logic             ack_r,      ack_nxt;

  // ****************************************
  // protection state
  // ****************************************
  logic             blk_smp_r,  blk_smp_nxt;
  logic             trip_r,     trip_nxt;
  logic             blocked_r,  blocked_nxt;
  logic [1:0]       cond_r,     cond_nxt;
  logic [CUR_W-1:0] diff_r,     diff_nxt;
  logic [3:0]       ev_r,       ev_nxt;
  logic [3:0]       store_r,    store_nxt;
  logic [47:0]      stamp_r,    stamp_nxt;
  logic [CUR_W-1:0] bias_max_r, bias_max_nxt;
  logic [CUR_W-1:0] diff_max_r, diff_max_nxt;
  logic [CUR_W-1:0] chr_max_r,  chr_max_nxt;

  // ****************************************
  // record log
  // ****************************************
  log_rec_s         log_mem_r [LOG_DEPTH];
  logic [3:0]       wr_idx_r,   wr_idx_nxt;
  logic [4:0]       fill_r,     fill_nxt;
  logic             log_we;
  log_rec_s         log_new;

  logic             bus_req;
  logic             wr_ctrl;
  logic             wr_cmd;
  logic             wr_sel;
  logic [CUR_W-1:0] res_sel;
  logic [CUR_W-1:0] diff_now;
  logic [3:0]       ev_now;
  log_rec_s         rd_rec;
  logic [31:0]      rd_word;

  assign bus_req = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr_ctrl = bus_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == `REF_ADR_CTRL);
  assign wr_cmd  = bus_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == `REF_ADR_CMD);
  assign wr_sel  = bus_req && i_wb_we && i_wb_sel[0] && (i_wb_adr == `REF_ADR_LOG_SEL);

  // ****************************************
  // differential current
  // ****************************************
  always_comb
  begin
    res_sel = ctrl_r[`REF_CTRL_INSEL_BIT] ? i_measured_residual_current_2
                                          : i_measured_residual_current_1;
    if (ctrl_r[`REF_CTRL_DIR_BIT])
      diff_now = i_computed_residual_current - res_sel;
    else
      diff_now = i_computed_residual_current + res_sel;
  end

  // ****************************************
  // trip and block arbitration
  // ****************************************
  always_comb
  begin
    blk_smp_nxt  = blk_smp_r;
    trip_nxt     = trip_r;
    blocked_nxt  = blocked_r;
    ev_nxt       = 4'h0;
    ev_now       = 4'h0;
    store_nxt    = 4'h0;
    stamp_nxt    = stamp_r;
    diff_nxt     = diff_now;
    bias_max_nxt = bias_max_r;
    diff_max_nxt = diff_max_r;
    chr_max_nxt  = chr_max_r;
    if (i_cycle_tick)
    begin
      blk_smp_nxt = blk_sync_r;
      if (!i_pickup)
      begin
        trip_nxt    = 1'b0;
        blocked_nxt = 1'b0;
      end
      else if (trip_r && blk_sync_r)
      begin
        // trip falls, outer timer sees a drop and runs its release
        trip_nxt    = 1'b0;
        blocked_nxt = 1'b1;
      end
      else if (!trip_r && !blocked_r)
      begin
        trip_nxt    = !blk_sync_r;
        blocked_nxt = blk_sync_r;
      end
      ev_now[`REF_EV_TRIP_ON]  = trip_nxt && !trip_r;
      ev_now[`REF_EV_TRIP_OFF] = !trip_nxt && trip_r;
      ev_now[`REF_EV_BLK_ON]   = blocked_nxt && !blocked_r;
      ev_now[`REF_EV_BLK_OFF]  = !blocked_nxt && blocked_r;
      ev_nxt    = ev_now;
      store_nxt = ev_now & ctrl_r[`REF_CTRL_MASK_MSB:`REF_CTRL_MASK_LSB];
      if (ev_now != 4'h0)
        stamp_nxt = i_time_stamp;
    end
    // maxima restart with every new pick-up
    if (!i_pickup)
    begin
      bias_max_nxt = '0;
      diff_max_nxt = '0;
      chr_max_nxt  = '0;
    end
    else
    begin
      if (i_bias_current > bias_max_r)
        bias_max_nxt = i_bias_current;
      if (diff_now > diff_max_r)
        diff_max_nxt = diff_now;
      if (i_threshold_current > chr_max_r)
        chr_max_nxt = i_threshold_current;
    end
    if (trip_nxt)
      cond_nxt = COND_TRIP;
    else if (blocked_nxt)
      cond_nxt = COND_BLOCKED;
    else
      cond_nxt = COND_NORMAL;
  end

  // ****************************************
  // counters, log pointer and bus
  // ****************************************
  always_comb
  begin
    log_new            = '0;
    log_new.stamp      = i_time_stamp;
    log_new.event_code = ev_now[`REF_EV_TRIP_ON] ? 2'(`REF_EV_TRIP_ON) : 2'(`REF_EV_BLK_ON);
    log_new.group      = i_setting_group;
    log_new.bias       = 16'(i_bias_current);
    log_new.diff       = 16'(diff_now);
    log_new.chr        = 16'(i_threshold_current);
    log_new.bias_max   = 16'((i_bias_current > bias_max_r) ? i_bias_current : bias_max_r);
    log_new.diff_max   = 16'((diff_now > diff_max_r) ? diff_now : diff_max_r);
    log_new.chr_max    = 16'((i_threshold_current > chr_max_r) ? i_threshold_current : chr_max_r);
    log_new.calc       = 16'(i_computed_residual_current);
    log_new.meas       = 16'(res_sel);
    log_we = ev_now[`REF_EV_TRIP_ON] || ev_now[`REF_EV_BLK_ON];

    wr_idx_nxt = wr_idx_r;
    fill_nxt   = fill_r;
    if (log_we)
    begin
      wr_idx_nxt = (wr_idx_r == LAST_IDX) ? 4'h0 : wr_idx_r + 4'h1;
      if (fill_r != 5'(LOG_DEPTH))
        fill_nxt = fill_r + 5'h1;
    end

    // an occurrence in the clearing cycle still counts
    trip_cnt_nxt = trip_cnt_r;
    blk_cnt_nxt  = blk_cnt_r;
    if (wr_cmd && i_wb_dat[`REF_CMD_CLR_TRIP_BIT])
      trip_cnt_nxt = '0;
    if (wr_cmd && i_wb_dat[`REF_CMD_CLR_BLK_BIT])
      blk_cnt_nxt = '0;
    if (ev_now[`REF_EV_TRIP_ON])
      trip_cnt_nxt = trip_cnt_nxt + CNT_W'(1);
    if (ev_now[`REF_EV_BLK_ON])
      blk_cnt_nxt = blk_cnt_nxt + CNT_W'(1);

    ctrl_nxt = wr_ctrl ? i_wb_dat[7:0] : ctrl_r;
    sel_nxt  = wr_sel ? i_wb_dat[7:0] : sel_r;

    if (sel_r[`REF_SEL_IDX_MSB:`REF_SEL_IDX_LSB] <= LAST_IDX)
      rd_rec = log_mem_r[sel_r[`REF_SEL_IDX_MSB:`REF_SEL_IDX_LSB]];
    else
      rd_rec = '0;
    case (sel_r[`REF_SEL_WORD_MSB:`REF_SEL_WORD_LSB])
      3'h0:    rd_word = rd_rec.stamp[31:0];
      3'h1:    rd_word = {rd_rec.event_code, 3'h0, rd_rec.group, 8'h00, rd_rec.stamp[47:32]};
      3'h2:    rd_word = {rd_rec.diff, rd_rec.bias};
      3'h3:    rd_word = {rd_rec.bias_max, rd_rec.chr};
      3'h4:    rd_word = {rd_rec.chr_max, rd_rec.diff_max};
      3'h5:    rd_word = {rd_rec.meas, rd_rec.calc};
      default: rd_word = 32'h0;
    endcase

    ack_nxt  = bus_req;
    rdat_nxt = 32'h0;
    if (bus_req && !i_wb_we)
    begin
      case (i_wb_adr)
        `REF_ADR_CTRL:     rdat_nxt = {24'h0, ctrl_r};
        `REF_ADR_STATUS:   rdat_nxt = {27'h0, blk_smp_r, blocked_r, trip_r, cond_r};
        `REF_ADR_TRIP_CNT: rdat_nxt = 32'(trip_cnt_r);
        `REF_ADR_BLK_CNT:  rdat_nxt = 32'(blk_cnt_r);
        `REF_ADR_LOG_PTR:  rdat_nxt = {19'h0, fill_r, 4'h0, wr_idx_r};
        `REF_ADR_LOG_SEL:  rdat_nxt = {24'h0, sel_r};
        `REF_ADR_LOG_DATA: rdat_nxt = rd_word;
        default:           rdat_nxt = 32'h0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_r     <= `REF_CTRL_RESET;
      sel_r      <= 8'h00;
      trip_cnt_r <= '0;
      blk_cnt_r  <= '0;
      rdat_r     <= 32'h0;
      ack_r      <= 1'b0;
      blk_smp_r  <= 1'b0;
      trip_r     <= 1'b0;
      blocked_r  <= 1'b0;
      cond_r     <= COND_NORMAL;
      diff_r     <= '0;
      ev_r       <= 4'h0;
      store_r    <= 4'h0;
      stamp_r    <= 48'h0;
      bias_max_r <= '0;
      diff_max_r <= '0;
      chr_max_r  <= '0;
      wr_idx_r   <= 4'h0;
      fill_r     <= 5'h0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      sel_r      <= sel_nxt;
      trip_cnt_r <= trip_cnt_nxt;
      blk_cnt_r  <= blk_cnt_nxt;
      rdat_r     <= rdat_nxt;
      ack_r      <= ack_nxt;
      blk_smp_r  <= blk_smp_nxt;
      trip_r     <= trip_nxt;
      blocked_r  <= blocked_nxt;
      cond_r     <= cond_nxt;
      diff_r     <= diff_nxt;
      ev_r       <= ev_nxt;
      store_r    <= store_nxt;
      stamp_r    <= stamp_nxt;
      bias_max_r <= bias_max_nxt;
      diff_max_r <= diff_max_nxt;
      chr_max_r  <= chr_max_nxt;
      wr_idx_r   <= wr_idx_nxt;
      fill_r     <= fill_nxt;
    end
  end

  // log storage has no reset; fill count tells which entries are valid
  always_ff @(posedge i_sys_clk)
  begin
    if (log_we)
      log_mem_r[wr_idx_r] <= log_new;
  end

  assign o_wb_dat       = rdat_r;
  assign o_wb_ack       = ack_r;
  assign o_trip         = trip_r;
  assign o_blocked      = blocked_r;
  assign o_condition    = cond_r;
  assign o_diff_current = diff_r;
  assign o_event_pulse  = ev_r;
  assign o_event_store  = store_r;
  assign o_event_stamp  = stamp_r;

endmodule : ref_stage

`default_nettype wire

//--- bench/ref_stage_properties.sv
// port-level assertions for the residual differential stage
// assumes a bind onto ref_stage, single clock domain
`timescale 1ns/1ps
`default_nettype none
module ref_stage_properties
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       o_wb_ack,
  input wire logic       i_cycle_tick,
  input wire logic       i_block_in,
  input wire logic       i_pickup,
  input wire logic       o_trip,
  input wire logic       o_blocked,
  input wire logic [1:0] o_condition,
  input wire logic [3:0] o_event_pulse,
  input wire logic [3:0] o_event_store
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ****
  // properties
  // ****
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  property p_ack_drop; o_wb_ack |=> !o_wb_ack; endproperty
  // block value two edges back is what the sync chain delivers at the tick
  property p_trip_set;
    i_cycle_tick && i_pickup && !o_trip && !o_blocked && !$past(i_block_in, 2) |=> o_trip && !o_blocked;
  endproperty
  property p_block_set;
    i_cycle_tick && i_pickup && !o_trip && $past(i_block_in, 2) |=> o_blocked && !o_trip;
  endproperty
  property p_trip_clr; i_cycle_tick && o_trip && $past(i_block_in, 2) |=> !o_trip && o_event_pulse[1]; endproperty
  property p_drop; i_cycle_tick && !i_pickup |=> !o_trip && !o_blocked; endproperty
  property p_hold; !i_cycle_tick |=> $stable(o_trip) && $stable(o_blocked); endproperty
  property p_cond; o_condition == {o_blocked, o_trip}; endproperty
  property p_on; $rose(o_trip) |-> o_event_pulse[0] && !o_event_pulse[1]; endproperty
  property p_off; $fell(o_blocked) |-> o_event_pulse[3]; endproperty
  property p_store; (o_event_store & ~o_event_pulse) == 4'h0; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  a_trip_set: assert property (p_trip_set) else $error("no trip");
  a_block_set: assert property (p_block_set) else $error("no blocked");
  a_trip_clr: assert property (p_trip_clr) else $error("trip kept");
  a_drop: assert property (p_drop) else $error("status kept");
  a_hold: assert property (p_hold) else $error("change off tick");
  a_cond: assert property (p_cond) else $error("bad condition");
  a_on: assert property (p_on) else $error("missing on event");
  a_off: assert property (p_off) else $error("missing off event");
  a_store: assert property (p_store) else $error("stray store");
  c_trip: cover property ($rose(o_trip));
  c_swap: cover property (o_trip ##1 o_blocked);
  c_ack: cover property (o_wb_ack);
endmodule : ref_stage_properties
bind ref_stage ref_stage_properties u_props (.*);
`default_nettype wire

//--- bench/ref_matrix_model.sv
// blocking matrix and user logic feeding the stage
// assumes one clock; levels move only just after a tick
`timescale 1ns/1ps
`default_nettype none
module ref_matrix_model #(
  parameter int TICK_PER = 8
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_block_req,
  input  wire logic i_pickup_req,
  output var  logic o_cycle_tick,
  output var  logic o_block_in,
  output var  logic o_pickup
);
  logic [7:0] cnt_r;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= 8'h00;
      o_cycle_tick <= 1'b0;
      o_block_in <= 1'b0;
      o_pickup <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == 8'(TICK_PER - 1)) ? 8'h00 : cnt_r + 8'h01;
      o_cycle_tick <= (cnt_r == 8'(TICK_PER - 1));
      // a whole program cycle of lead before the next sample
      if (o_cycle_tick)
      begin
        o_block_in <= i_block_req;
        o_pickup <= i_pickup_req;
      end
    end
  end
endmodule : ref_matrix_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the residual differential stage
// assumes ref_matrix_model drives tick, block and pick-up
`include "ref_stage_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, clr = 0, blk_req = 0, pu_req = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [15:0] calc = 16'h0064, m1 = 16'h001e, m2 = 16'h0007, diff;
  logic [47:0] ts = 48'h1234_0000_0abc, stamp;
  logic ack, trip, blocked, tick, blk, pu;
  logic [1:0] cond;
  logic [3:0] ev, st, seen_ev = 4'h0, seen_st = 4'h0;
  int error_cnt = 0, checked = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    seen_ev <= clr ? 4'h0 : seen_ev | ev;
    seen_st <= clr ? 4'h0 : seen_st | st;
  end
  ref_matrix_model #(.TICK_PER(8)) u_matrix (.i_sys_clk(clk), .i_rst(rst), .i_block_req(blk_req),
    .i_pickup_req(pu_req), .o_cycle_tick(tick), .o_block_in(blk), .o_pickup(pu));
  ref_stage DUT (.i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_cycle_tick(tick), .i_block_in(blk), .i_pickup(pu), .i_computed_residual_current(calc),
    .i_measured_residual_current_1(m1), .i_measured_residual_current_2(m2),
    .i_bias_current(16'h0020), .i_threshold_current(16'h0040), .i_time_stamp(ts),
    .i_setting_group(3'h5), .o_trip(trip), .o_blocked(blocked), .o_condition(cond),
    .o_diff_current(diff), .o_event_pulse(ev), .o_event_store(st), .o_event_stamp(stamp));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, {16'h0, e}, {16'h0, q});
  endtask : rd
  task automatic lg(input logic [7:0] s, input logic [31:0] e, input string nm);
    wb(1'b1, `REF_ADR_LOG_SEL, {24'h0, s}, 4'hf);
    rd(`REF_ADR_LOG_DATA, e, nm);
  endtask : lg
  task automatic step(input logic b, input logic p);
    clr <= 1'b1;
    blk_req <= b;
    pu_req <= p;
    @(posedge clk);
    clr <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : step
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`REF_ADR_CTRL, 32'hf0, "ctrl");
    rd(8'h20, 32'h0, "unmapped");
    wb(1'b1, `REF_ADR_CTRL, 32'h11, 4'h2);
    rd(`REF_ADR_CTRL, 32'hf0, "ctrl no sel");
    wb(1'b1, `REF_ADR_CTRL, 32'h10, 4'hf);
    rd(`REF_ADR_CTRL, 32'h10, "ctrl");
    step(1'b0, 1'b1);
    chk("trip", 48'h1, {47'h0, trip});
    rd(`REF_ADR_STATUS, 32'h05, "status");
    chk("cond trip", 48'h1, {46'h0, cond});
    chk("events", 48'h1, {44'h0, seen_ev});
    chk("stored", 48'h1, {44'h0, seen_st});
    chk("stamp", ts, stamp);
    rd(`REF_ADR_TRIP_CNT, 32'h1, "trips");
    $display("test trip done");
    step(1'b1, 1'b1);
    rd(`REF_ADR_STATUS, 32'h1a, "status");
    chk("blocked", 48'h1, {47'h0, blocked});
    chk("cond blocked", 48'h2, {46'h0, cond});
    chk("events", 48'h6, {44'h0, seen_ev});
    chk("stored", 48'h0, {44'h0, seen_st});
    wb(1'b1, `REF_ADR_STATUS, 32'h0, 4'hf);
    rd(`REF_ADR_STATUS, 32'h1a, "status ro");
    step(1'b1, 1'b0);
    rd(`REF_ADR_STATUS, 32'h10, "status");
    chk("events", 48'h8, {44'h0, seen_ev});
    step(1'b1, 1'b1);
    rd(`REF_ADR_STATUS, 32'h1a, "status");
    chk("events", 48'h4, {44'h0, seen_ev});
    rd(`REF_ADR_TRIP_CNT, 32'h1, "trips");
    rd(`REF_ADR_BLK_CNT, 32'h2, "blocks");
    $display("test blocking done");
    step(1'b0, 1'b0);
    rd(`REF_ADR_LOG_PTR, 32'h0303, "log ptr");
    lg(8'h01, 32'h0500_1234, "log0 w1");
    lg(8'h11, 32'h8500_1234, "log1 w1");
    lg(8'h00, 32'h0000_0abc, "log0 w0");
    lg(8'h02, 32'h0082_0020, "log0 w2");
    lg(8'h03, 32'h0020_0040, "log0 w3");
    lg(8'h04, 32'h0040_0082, "log0 w4");
    lg(8'h05, 32'h001e_0064, "log0 w5");
    lg(8'hc1, 32'h0, "log12");
    wb(1'b1, `REF_ADR_CMD, 32'h3, 4'hf);
    rd(`REF_ADR_TRIP_CNT, 32'h0, "trips");
    rd(`REF_ADR_BLK_CNT, 32'h0, "blocks");
    // ten more trip records: thirteen in all, so the index wraps past the last entry
    repeat (10)
    begin
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
    end
    rd(`REF_ADR_LOG_PTR, 32'h0c01, "log wrap");
    rd(`REF_ADR_TRIP_CNT, 32'ha, "trips");
    $display("test log done");
    chk("diff add", 48'h82, {32'h0, diff});
    wb(1'b1, `REF_ADR_CTRL, 32'h1, 4'hf);
    repeat (2) @(posedge clk);
    chk("diff sub", 48'h46, {32'h0, diff});
    wb(1'b1, `REF_ADR_CTRL, 32'h3, 4'hf);
    repeat (2) @(posedge clk);
    chk("diff in2", 48'h5d, {32'h0, diff});
    $display("test diff done");
    stop_test;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule : tb
`default_nettype wire
